// File: rtl/epic_ctrl.sv
// external pin interrupt control: pin gate, waveform select, request flag, accept logic
// Notes on behaviour
// - gate bit clear blocks the interrupt pin from the request logic
// - gate bit reads zero after reset, pin input starts disabled
// - enabled wakeup with pin already requesting leaves backup at once
// - with no oscillator selected the on-chip oscillator stays the source
// - changing select or gate may set the request flag, per pin level
// - the skip-test read clears the external request flag
// - no nesting: while servicing, no other interrupt is accepted
// - acceptance clears the global interrupt enable flag
// - enable just before return takes effect only when the return completes
`timescale 1ns/1ns
module epic_ctrl (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic i_shared_port_irq_pin,
   output logic o_irq_req,
   output logic o_irq_accept,
   output logic o_global_irq_enable,
   output logic o_in_service,
   output logic o_backup,
   output logic o_wakeup,
   output epic_pkg::epic_osc_type o_osc_sel
);
   import epic_pkg::*;
   `include "epic_cfg.svh"

   // ----------------------------------------------------------------
   // address decode helper
   // ----------------------------------------------------------------
   // word hit: the low two byte-address bits must be zero
   function automatic logic epic_hit(input logic [4:0] addr, input logic [4:0] base);
      epic_hit = (addr == base);
   endfunction

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic rd_capture;
   logic rd_done;
   logic wr_done;
   logic pin_level;
   logic [3:0] pin_ctrl_r;
   logic [3:0] pin_ctrl_nxt;
   logic [3:0] irq_en_ctrl_r;
   logic [3:0] irq_en_ctrl_nxt;
   logic [3:0] wakeup_sel_r;
   logic [3:0] wakeup_sel_nxt;
   logic ext_request_flag_r;
   logic ext_request_flag_nxt;
   logic global_irq_enable_flag_r;
   logic global_irq_enable_flag_nxt;
   logic in_service_r;
   logic in_service_nxt;
   logic ei_pending_r;
   logic ei_pending_nxt;
   logic eff_prev_r;
   logic accept_r;
   logic wakeup_r;
   logic [31:0] readdata_r;
   logic [31:0] readdata_nxt;
   epic_pwr_type pwr_r;
   epic_pwr_type pwr_nxt;
   epic_osc_type osc_r;
   epic_osc_type osc_nxt;

   // ----------------------------------------------------------------
   // bus handshake and pin synchroniser
   // ----------------------------------------------------------------
   epic_avs_hs u_hs (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_read(i_avs_read),
      .i_write(i_avs_write),
      .o_waitrequest(o_avs_waitrequest),
      .o_rd_capture(rd_capture),
      .o_rd_done(rd_done),
      .o_wr_done(wr_done)
   );

   epic_pin_sync u_sync (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_pin(i_shared_port_irq_pin),
      .o_level(pin_level)
   );

   // ----------------------------------------------------------------
   // register write decode
   // ----------------------------------------------------------------
   // all fields live in the low byte, so only lane zero matters
   wire lane0 = i_avs_byteenable[0];
   wire hit_pin_ctrl = epic_hit(i_avs_address, `EPIC_ADDR_PIN_CTRL);
   wire hit_ien_ctrl = epic_hit(i_avs_address, `EPIC_ADDR_IEN_CTRL);
   wire hit_wake_sel = epic_hit(i_avs_address, `EPIC_ADDR_WAKE_SEL);
   wire hit_status = epic_hit(i_avs_address, `EPIC_ADDR_STATUS);
   wire hit_skip = epic_hit(i_avs_address, `EPIC_ADDR_SKIP_TEST);
   wire hit_cmd = epic_hit(i_avs_address, `EPIC_ADDR_COMMAND);
   wire wr_pin_ctrl = wr_done & lane0 & hit_pin_ctrl;
   wire wr_ien_ctrl = wr_done & lane0 & hit_ien_ctrl;
   wire wr_wake_sel = wr_done & lane0 & hit_wake_sel;
   wire wr_cmd = wr_done & lane0 & hit_cmd;

   // ----------------------------------------------------------------
   // instruction strobes from the command register
   // ----------------------------------------------------------------
   wire cmd_ei = wr_cmd & i_avs_writedata[`EPIC_CMD_EI_BIT];
   wire cmd_di = wr_cmd & i_avs_writedata[`EPIC_CMD_DI_BIT];
   wire cmd_rti = wr_cmd & i_avs_writedata[`EPIC_CMD_RTI_BIT];
   wire cmd_backup = wr_cmd & i_avs_writedata[`EPIC_CMD_BACKUP_BIT];
   wire cmd_reson = wr_cmd & i_avs_writedata[`EPIC_CMD_RESON_BIT];
   wire cmd_rcosc = wr_cmd & i_avs_writedata[`EPIC_CMD_RCOSC_BIT];
   // any other command between enable and return breaks the pairing
   wire cmd_other = wr_cmd & ~i_avs_writedata[`EPIC_CMD_EI_BIT]
                    & ~i_avs_writedata[`EPIC_CMD_RTI_BIT];

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   assign pin_ctrl_nxt = wr_pin_ctrl ? i_avs_writedata[3:0] : pin_ctrl_r;
   assign irq_en_ctrl_nxt = wr_ien_ctrl ? i_avs_writedata[3:0] : irq_en_ctrl_r;
   assign wakeup_sel_nxt = wr_wake_sel ? i_avs_writedata[3:0] : wakeup_sel_r;

   // gate bit resets to zero, pin input starts disabled
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_ctrl_r <= `EPIC_PIN_CTRL_RST;
         irq_en_ctrl_r <= `EPIC_IEN_CTRL_RST;
         wakeup_sel_r <= `EPIC_WAKE_SEL_RST;
      end else begin
         pin_ctrl_r <= pin_ctrl_nxt;
         irq_en_ctrl_r <= irq_en_ctrl_nxt;
         wakeup_sel_r <= wakeup_sel_nxt;
      end
   end

   // ----------------------------------------------------------------
   // pin gate and valid-waveform select
   // ----------------------------------------------------------------
   // the select bit picks rising (1) or falling (0) as the valid edge;
   // folding it into the level means a toggle of select or gate can
   // itself look like an edge, which software must tidy up afterwards
   wire gate_on = pin_ctrl_r[`EPIC_PIN_GATE_BIT];
   wire pol_rise = pin_ctrl_r[`EPIC_PIN_POL_BIT];
   wire pol_level = pol_rise ? pin_level : ~pin_level;
   wire eff_level = gate_on & pol_level;
   wire ext_set = eff_level & ~eff_prev_r;

   // ----------------------------------------------------------------
   // acceptance
   // ----------------------------------------------------------------
   wire ext_enable = irq_en_ctrl_r[`EPIC_IEN_EXT_BIT];
   wire running = (pwr_r == EPIC_PWR_RUN);
   wire accept = ext_request_flag_r & ext_enable & global_irq_enable_flag_r
                 & ~in_service_r & running;
   // skip-test read clears the flag when the read completes
   wire skip_clr = rd_done & hit_skip;

   // ----------------------------------------------------------------
   // request flag: a new edge wins over any clear in the same cycle
   // ----------------------------------------------------------------
   assign ext_request_flag_nxt = ext_set | (ext_request_flag_r & ~(skip_clr | accept));

   // ----------------------------------------------------------------
   // global enable, service state and deferred enable
   // ----------------------------------------------------------------
   // enable issued while servicing is held back until the return
   always_comb begin
      global_irq_enable_flag_nxt = global_irq_enable_flag_r;
      if (accept) begin
         global_irq_enable_flag_nxt = 1'b0;
      end else if (cmd_rti) begin
         global_irq_enable_flag_nxt = ei_pending_r;
      end else if (cmd_di) begin
         global_irq_enable_flag_nxt = 1'b0;
      end else if (cmd_ei & ~in_service_r) begin
         global_irq_enable_flag_nxt = 1'b1;
      end
   end

   // pending enable survives to the return unless another command comes first
   always_comb begin
      ei_pending_nxt = ei_pending_r;
      if (accept | cmd_rti | cmd_other) begin
         ei_pending_nxt = 1'b0;
      end else if (cmd_ei & in_service_r) begin
         ei_pending_nxt = 1'b1;
      end
   end

   // one interrupt at a time
   always_comb begin
      in_service_nxt = in_service_r;
      if (accept) begin
         in_service_nxt = 1'b1;
      end else if (cmd_rti) begin
         in_service_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // power state: run and ram back-up
   // ----------------------------------------------------------------
   // key-on wakeup on this pin asks for wakeup at low level; if the pin
   // already sits low on entry the block leaves back-up the next cycle
   wire wake_enable = wakeup_sel_r[`EPIC_WAKE_PIN_BIT];
   wire wake_request = wake_enable & ~pin_level;

   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         EPIC_PWR_RUN: begin
            if (cmd_backup) begin
               pwr_nxt = EPIC_PWR_BACKUP;
            end
         end
         EPIC_PWR_BACKUP: begin
            if (wake_request) begin
               pwr_nxt = EPIC_PWR_RUN;
            end
         end
         default: begin
            pwr_nxt = EPIC_PWR_RUN;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // clock source selection
   // ----------------------------------------------------------------
   // on-chip source stays until software picks another one
   always_comb begin
      osc_nxt = osc_r;
      if (cmd_reson) begin
         osc_nxt = EPIC_OSC_RESONATOR;
      end else if (cmd_rcosc) begin
         osc_nxt = EPIC_OSC_RC;
      end
   end

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_request_flag_r <= 1'b0;
         global_irq_enable_flag_r <= 1'b0;
         in_service_r <= 1'b0;
         ei_pending_r <= 1'b0;
         eff_prev_r <= 1'b0;
         pwr_r <= EPIC_PWR_RUN;
         osc_r <= EPIC_OSC_ONCHIP;
      end else begin
         ext_request_flag_r <= ext_request_flag_nxt;
         global_irq_enable_flag_r <= global_irq_enable_flag_nxt;
         in_service_r <= in_service_nxt;
         ei_pending_r <= ei_pending_nxt;
         eff_prev_r <= eff_level;
         pwr_r <= pwr_nxt;
         osc_r <= osc_nxt;
      end
   end

   // event pulses, one cycle each
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         accept_r <= 1'b0;
         wakeup_r <= 1'b0;
      end else begin
         accept_r <= accept;
         wakeup_r <= (pwr_r == EPIC_PWR_BACKUP) & wake_request;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // status word gathers the live state in one place
   wire [7:0] status_byte = {
      1'b0,
      osc_r,
      pin_level,
      (pwr_r == EPIC_PWR_BACKUP),
      in_service_r,
      global_irq_enable_flag_r,
      ext_request_flag_r
   };

   // unmapped addresses read as zero
   always_comb begin
      readdata_nxt = `EPIC_READDATA_RST;
      if (hit_pin_ctrl) begin
         readdata_nxt = {28'h000_0000, pin_ctrl_r};
      end else if (hit_ien_ctrl) begin
         readdata_nxt = {28'h000_0000, irq_en_ctrl_r};
      end else if (hit_wake_sel) begin
         readdata_nxt = {28'h000_0000, wakeup_sel_r};
      end else if (hit_status) begin
         readdata_nxt = {24'h00_0000, status_byte};
      end else if (hit_skip) begin
         readdata_nxt = {31'h0000_0000, ext_request_flag_r};
      end
   end

   // captured in the wait cycle, stable at the completing edge
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         readdata_r <= `EPIC_READDATA_RST;
      end else if (rd_capture) begin
         readdata_r <= readdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_avs_readdata = readdata_r;
   assign o_irq_req = ext_request_flag_r & ext_enable;
   assign o_irq_accept = accept_r;
   assign o_global_irq_enable = global_irq_enable_flag_r;
   assign o_in_service = in_service_r;
   assign o_backup = (pwr_r == EPIC_PWR_BACKUP);
   assign o_wakeup = wakeup_r;
   assign o_osc_sel = osc_r;

endmodule // epic_ctrl

// File: include/epic_cfg.svh
// offsets, field positions and reset values of the external pin interrupt control
`ifndef EPIC_CFG_SVH
`define EPIC_CFG_SVH

// ----------------------------------------------------------------
// register byte addresses (one aligned word each)
// ----------------------------------------------------------------
`define EPIC_ADDR_PIN_CTRL 5'h00
`define EPIC_ADDR_IEN_CTRL 5'h04
`define EPIC_ADDR_WAKE_SEL 5'h08
`define EPIC_ADDR_STATUS 5'h0C
`define EPIC_ADDR_SKIP_TEST 5'h10
`define EPIC_ADDR_COMMAND 5'h14

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EPIC_PIN_POL_BIT 2
`define EPIC_PIN_GATE_BIT 3
`define EPIC_IEN_EXT_BIT 0
`define EPIC_WAKE_PIN_BIT 3
`define EPIC_CMD_EI_BIT 0
`define EPIC_CMD_DI_BIT 1
`define EPIC_CMD_RTI_BIT 2
`define EPIC_CMD_BACKUP_BIT 3
`define EPIC_CMD_RESON_BIT 4
`define EPIC_CMD_RCOSC_BIT 5
`define EPIC_ST_FLAG_BIT 0
`define EPIC_ST_GIE_BIT 1
`define EPIC_ST_INSVC_BIT 2
`define EPIC_ST_BACKUP_BIT 3
`define EPIC_ST_LEVEL_BIT 4
`define EPIC_ST_OSC_LSB 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EPIC_PIN_CTRL_RST 4'h0
`define EPIC_IEN_CTRL_RST 4'h0
`define EPIC_WAKE_SEL_RST 4'h0
`define EPIC_PIN_IDLE_RST 1'b1
`define EPIC_READDATA_RST 32'h0000_0000

`endif

// File: include/epic_pkg.sv
// types shared by the external pin interrupt control
package epic_pkg;

   // system clock source
   typedef enum logic [1:0] {
      EPIC_OSC_ONCHIP,
      EPIC_OSC_RESONATOR,
      EPIC_OSC_RC
   } epic_osc_type;

   // power state
   typedef enum logic {
      EPIC_PWR_RUN,
      EPIC_PWR_BACKUP
   } epic_pwr_type;

endpackage

// File: rtl/epic_pin_sync.sv
// three-stage synchroniser with agreement filter for the interrupt pin
`timescale 1ns/1ns
module epic_pin_sync (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_pin,
   output logic o_level
);
   import epic_pkg::*;
   `include "epic_cfg.svh"

   // ----------------------------------------------------------------
   // synchroniser chain
   // ----------------------------------------------------------------
   logic meta_r;
   logic s2_r;
   logic s3_r;
   logic level_r;
   logic level_nxt;

   // level only moves once stages two and three agree
   assign level_nxt = (s2_r == s3_r) ? s3_r : level_r;
   assign o_level = level_r;

   // stage one is read by stage two only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_r <= `EPIC_PIN_IDLE_RST;
         s2_r <= `EPIC_PIN_IDLE_RST;
         s3_r <= `EPIC_PIN_IDLE_RST;
         level_r <= `EPIC_PIN_IDLE_RST;
      end else begin
         meta_r <= i_pin;
         s2_r <= meta_r;
         s3_r <= s2_r;
         level_r <= level_nxt;
      end
   end
endmodule // epic_pin_sync

// File: rtl/epic_avs_hs.sv
// avalon-mm slave handshake: one wait state per access
`timescale 1ns/1ns
module epic_avs_hs (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_read,
   input wire logic i_write,
   output logic o_waitrequest,
   output logic o_rd_capture,
   output logic o_rd_done,
   output logic o_wr_done
);
   import epic_pkg::*;

   // ----------------------------------------------------------------
   // handshake
   // ----------------------------------------------------------------
   logic ack_r;
   logic req;

   // first cycle of a request waits, second completes
   assign req = i_read | i_write;
   assign o_waitrequest = req & ~ack_r;
   assign o_rd_capture = i_read & ~ack_r;
   assign o_rd_done = i_read & ack_r;
   assign o_wr_done = i_write & ack_r;

   // ack lasts exactly one cycle so back-to-back requests each wait once
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= req & ~ack_r;
      end
   end
endmodule // epic_avs_hs

// File: tb/epic_ctrl_asserts.sv
// port-level checks of the external pin interrupt control, bound into the top module
`timescale 1ns/1ns
`include "epic_cfg.svh"
module epic_ctrl_asserts (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic i_shared_port_irq_pin,
   input wire logic o_irq_req,
   input wire logic o_irq_accept,
   input wire logic o_global_irq_enable,
   input wire logic o_in_service,
   input wire logic o_backup,
   input wire logic o_wakeup,
   input wire epic_pkg::epic_osc_type o_osc_sel
);
   import epic_pkg::*;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // completing edges of bus requests; commands need byte lane 0
   wire logic req = i_avs_read || i_avs_write;
   wire logic done = req && !o_avs_waitrequest;
   wire logic cmd_done = done && i_avs_write && i_avs_byteenable[0]
      && (i_avs_address == `EPIC_ADDR_COMMAND);
   wire logic skip_done = done && i_avs_read && (i_avs_address == `EPIC_ADDR_SKIP_TEST);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_wait_first;
      $rose(req) |-> o_avs_waitrequest;
   endproperty
   a_wait_first: assert property (p_wait_first) else $error("no wait state");
   property p_wait_one;
      req && o_avs_waitrequest |=> !o_avs_waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("more than one wait state");
   property p_acc_cause;
      o_irq_accept |-> $past(o_irq_req) && $past(o_global_irq_enable);
   endproperty
   a_acc_cause: assert property (p_acc_cause) else $error("accept without cause");
   property p_no_nest;
      o_irq_accept |-> !$past(o_in_service);
   endproperty
   a_no_nest: assert property (p_no_nest) else $error("nested accept");
   property p_acc_gie;
      o_irq_accept |-> !o_global_irq_enable && o_in_service;
   endproperty
   a_acc_gie: assert property (p_acc_gie) else $error("enable kept on accept");
   property p_defer;
      o_in_service |-> !o_global_irq_enable;
   endproperty
   a_defer: assert property (p_defer) else $error("enable while in service");
   property p_ret;
      cmd_done && i_avs_writedata[2] && o_in_service |=> !o_in_service;
   endproperty
   a_ret: assert property (p_ret) else $error("return left service on");
   property p_skip;
      skip_done |=> !o_irq_req;
   endproperty
   a_skip: assert property (p_skip) else $error("skip test kept request");
   property p_osc;
      $changed(o_osc_sel) |-> $past(cmd_done);
   endproperty
   a_osc: assert property (p_osc) else $error("clock source moved alone");
endmodule // epic_ctrl_asserts

bind epic_ctrl epic_ctrl_asserts i_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
   .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_shared_port_irq_pin(i_shared_port_irq_pin), .o_irq_req(o_irq_req),
   .o_irq_accept(o_irq_accept), .o_global_irq_enable(o_global_irq_enable),
   .o_in_service(o_in_service), .o_backup(o_backup), .o_wakeup(o_wakeup),
   .o_osc_sel(o_osc_sel));

// File: tb/epic_pin_src.sv
// behavioural source driving the shared interrupt pin
`timescale 1ns/1ns
module epic_pin_src #(
   parameter int DLY = 3
) (
   input wire logic i_drive_en,
   input wire logic i_level,
   output logic o_pin
);
   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // released pin floats to the pull-up; delay keeps edges off the clock grid
   assign #DLY o_pin = i_drive_en ? i_level : 1'b1;
endmodule // epic_pin_src

// File: tb/tb.sv
// self-checking bench for the external pin interrupt control
`timescale 1ns/1ns
`include "epic_cfg.svh"
module tb;
   import epic_pkg::*;
   logic i_clk, i_rst_n, rd, wr, pin_en, pin_lvl, pin;
   logic waitreq, irq_req, acc, gie, insvc, bkup, wake;
   logic [4:0] adr;
   logic [3:0] be;
   logic [31:0] wd, rdata, seed;
   logic [31:0] exp_q[$];
   epic_osc_type osc;
   int n_mismatch, num_checks, n_cyc, n_acc, k;
   // ----------------------------------------------------------------
   // partner and design
   // ----------------------------------------------------------------
   epic_pin_src #(.DLY(3)) i_src (.i_drive_en(pin_en), .i_level(pin_lvl), .o_pin(pin));
   epic_ctrl i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_avs_address(adr), .i_avs_read(rd),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(waitreq), .i_shared_port_irq_pin(pin), .o_irq_req(irq_req),
      .o_irq_accept(acc), .o_global_irq_enable(gie), .o_in_service(insvc), .o_backup(bkup),
      .o_wakeup(wake), .o_osc_sel(osc));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // random upper data bits prove that only the low byte counts
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one request, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
      logic [31:0] r;
      r = xs();
      @(posedge i_clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= {r[31:8], v};
      @(posedge i_clk);
      while (waitreq !== 1'b0) @(posedge i_clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask
   task automatic rdx(input logic [4:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 8'h00);
   endtask
   task automatic pin_set(input logic v);
      @(posedge i_clk);
      pin_lvl <= v;
      pin_en <= 1'b1;
      repeat (8) @(posedge i_clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // clock, monitor, timeout
   // ----------------------------------------------------------------
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // read data taken at the completing edge, oldest note first
   always @(posedge i_clk) begin
      if (rd === 1'b1 && waitreq === 1'b0) chk("readdata", exp_q.pop_front(), rdata);
      if (acc === 1'b1) n_acc++;
      n_cyc++;
      if (n_cyc == 6000) begin
         n_mismatch++;
         results();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h0001_4265;
      i_rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 5'h00;
      wd = 32'h0000_0000;
      be = 4'hf;
      pin_en = 1'b0;
      pin_lvl = 1'b1;
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      // reset view, unmapped and refused accesses
      rdx(`EPIC_ADDR_PIN_CTRL, 32'h0000_0000);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0010);
      rdx(5'h18, 32'h0000_0000);
      rdx(`EPIC_ADDR_COMMAND, 32'h0000_0000);
      be <= 4'h0;
      bus(1'b1, `EPIC_ADDR_PIN_CTRL, 8'h08);
      be <= 4'hf;
      rdx(`EPIC_ADDR_PIN_CTRL, 32'h0000_0000);
      // closed gate hides pin edges
      pin_set(1'b0);
      pin_set(1'b1);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0000);
      // opening the gate and flipping the edge select
      pin_set(1'b0);
      bus(1'b1, `EPIC_ADDR_PIN_CTRL, 8'h08);
      repeat (3) @(posedge i_clk);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0001);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0000);
      pin_set(1'b1);
      bus(1'b1, `EPIC_ADDR_PIN_CTRL, 8'h0c);
      repeat (3) @(posedge i_clk);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0001);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0000);
      // idle slot stands in for the no-operation after the skip-clear
      @(posedge i_clk);
      // acceptance, no nesting, enable deferred to return
      pin_set(1'b0);
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h01);
      pin_set(1'b1);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0013);
      chk("irq_req", 32'd0, {31'd0, irq_req});
      bus(1'b1, `EPIC_ADDR_IEN_CTRL, 8'h01);
      repeat (3) @(posedge i_clk);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0014);
      chk("in_service", 32'd1, {31'd0, insvc});
      pin_set(1'b0);
      pin_set(1'b1);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0015);
      chk("irq_req", 32'd1, {31'd0, irq_req});
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h01);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0015);
      rdx(`EPIC_ADDR_SKIP_TEST, 32'h0000_0001);
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h04);
      rdx(`EPIC_ADDR_STATUS, 32'h0000_0012);
      chk("gie", 32'd1, {31'd0, gie});
      chk("accepts", 32'd1, n_acc);
      // global enable off, then clock source selection
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h02);
      // individual enable off before the gate and select are touched again
      bus(1'b1, `EPIC_ADDR_IEN_CTRL, 8'h00);
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h10);
      @(posedge i_clk);
      chk("osc", {30'd0, EPIC_OSC_RESONATOR}, {30'd0, osc});
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h20);
      @(posedge i_clk);
      chk("osc", {30'd0, EPIC_OSC_RC}, {30'd0, osc});
      // back-up left at once while the pin asks for wakeup
      bus(1'b1, `EPIC_ADDR_WAKE_SEL, 8'h08);
      pin_set(1'b0);
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h08);
      for (k = 0; k < 20 && wake !== 1'b1; k++) @(posedge i_clk);
      chk("wakeup", 32'd1, {31'd0, wake});
      // back-up without wakeup: select and gate cleared first, pin released
      bus(1'b1, `EPIC_ADDR_WAKE_SEL, 8'h00);
      bus(1'b1, `EPIC_ADDR_PIN_CTRL, 8'h00);
      pin_en <= 1'b0;
      bus(1'b1, `EPIC_ADDR_COMMAND, 8'h08);
      repeat (10) @(posedge i_clk);
      chk("backup", 32'd1, {31'd0, bkup});
      results();
   end
endmodule // tb
